// ==== quad_dac_pkg.sv ====
// Purpose: Shared constants and types for the quad DAC serial command port.
// Assumes: 16-bit frames, most significant bit first.
// Notes:   Field positions are bit indices within the received word.
package quad_dac_pkg;
   localparam int FRAME_BITS    = 16;
   localparam int CODE_BITS     = 12;
   localparam int CHANNELS      = 4;
   localparam int CHAN_SEL_MSB  = 15;
   localparam int CHAN_SEL_LSB  = 14;
   localparam int CMD_MSB       = 13;
   localparam int CMD_LSB       = 12;
   localparam logic [1:0] CMD_SPECIAL = 2'h0;
   localparam logic [1:0] CMD_UPDATE  = 2'h2;
   localparam logic [1:0] CMD_LOAD    = 2'h1;
   localparam logic [1:0] CMD_LOAD_UP = 2'h3;
   localparam logic [11:0] CODE_RESET = 12'h000;
   // Echo mode: 1 shifts out on the rising edge, 0 on the falling edge.
   localparam logic MODE_RISING  = 1'b1;
   localparam logic MODE_FALLING = 1'b0;
   localparam logic MODE_RESET   = MODE_RISING;

   typedef struct packed {
      logic       channel_select_hi;
      logic       channel_select_lo;
      logic       command_hi;
      logic       command_lo;
      logic [11:0] sample_code;
   } frame_t;
endpackage

// ==== quad_dac_port.sv ====
// Purpose: Serial command port of a quad 12-bit DAC with per-channel input and DAC registers.
// Assumes: sck_i runs only inside frames; the shift register is quiet while cs_n_i is high.
// Notes:   The link side runs on sck_i, the register side on ref_clk_i.
// How it works
// - A frame is sixteen bits, channel, command, then twelve-bit code, MSB first.
// - SDI shifts in on SCK rising edges; the command acts when chip select rises.
// - SDO is the shift register output, lagging 16 or 16.5 cycles by mode.
// - Strobe high, command 01: load selected input register only.
// - Strobe high, command 11: load selected input register, then update all DACs.
// - Command 00 with A0 low: code goes into every input and DAC register.
// - Strobe high, A1 low, command 10: copy all input registers to DACs.
// - Word 1110 selects rising-edge echo and updates all DACs.
// - Word 1010 selects falling-edge echo and updates all DACs.
// - Strobe low with C0 set: load selected input register, its DAC follows.
// - Strobe low makes DAC registers transparent; high holds them.
// - Devices chain SDO into SDI; bits pass through the shift register.
`timescale 1ns/1ps
module quad_dac_port
   import quad_dac_pkg::*;
(
   // Register-side clock and reset
   input  wire logic                               ref_clk_i,
   input  wire logic                               rstn_i,
   // Serial link
   input  wire logic                               sck_i,
   input  wire logic                               cs_n_i,
   input  wire logic                               sdi_i,
   output logic                                    sdo_o,
   // Level latch control
   input  wire logic                               load_strobe_n_i,
   // DAC codes and status
   output logic [CHANNELS-1:0][CODE_BITS-1:0]      dac_code_o,
   output logic                                    echo_mode_o
);
   logic [FRAME_BITS-1:0]                shift_q;
   logic                                 sdo_fall_q;
   logic                                 mode_s1_q;
   logic                                 mode_s2_q;
   logic                                 cs_s1_q;
   logic                                 cs_s2_q;
   logic                                 cs_s3_q;
   logic                                 ld_s1_q;
   logic                                 ld_s2_q;
   logic                                 evt_q;
   frame_t                               word_q;
   logic [CHANNELS-1:0][CODE_BITS-1:0]   in_q;
   logic [CHANNELS-1:0][CODE_BITS-1:0]   in_d;
   logic [CHANNELS-1:0][CODE_BITS-1:0]   dac_q;
   logic [CHANNELS-1:0][CODE_BITS-1:0]   dac_d;
   logic                                 mode_q;
   logic                                 mode_d;
   logic [1:0]                           cmd;
   logic [1:0]                           chan;

   // Link domain: no reset, since sck_i may never tick while reset is held.
   always_ff @(posedge sck_i) begin
      if (!cs_n_i) begin
         shift_q <= {shift_q[FRAME_BITS-2:0], sdi_i};
      end
   end

   // The half-cycle extra lag is a falling-edge copy of the shift register output.
   always_ff @(negedge sck_i) begin
      sdo_fall_q <= shift_q[FRAME_BITS-1];
   end

   // Mode crosses as a level; a change takes hold after two link edges of the next frame.
   always_ff @(posedge sck_i) begin
      mode_s1_q <= mode_q;
      mode_s2_q <= mode_s1_q;
   end

   // The echo select only moves in the first two bits after a mode word, so those bits
   // of that frame must not be trusted by a host that reads the echo back.
   assign sdo_o = (mode_s2_q == MODE_RISING) ? shift_q[FRAME_BITS-1] : sdo_fall_q;

   // Register domain synchronisers.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         ld_s1_q <= 1'b1;
         ld_s2_q <= 1'b1;
      end else begin
         cs_s1_q <= cs_n_i;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         ld_s1_q <= load_strobe_n_i;
         ld_s2_q <= ld_s1_q;
      end
   end

   // The shift register is stable once chip select is high, so the word is sampled safely.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         evt_q  <= 1'b0;
         word_q <= '0;
      end else begin
         evt_q <= cs_s2_q & ~cs_s3_q;
         if (cs_s2_q & ~cs_s3_q) begin
            word_q <= frame_t'(shift_q);
         end
      end
   end

   assign cmd  = {word_q.command_hi, word_q.command_lo};
   assign chan = {word_q.channel_select_hi, word_q.channel_select_lo};

   // A command cycle owns the DAC update; the strobe copy resumes on the next cycle.
   always_comb begin
      in_d   = in_q;
      dac_d  = dac_q;
      mode_d = mode_q;
      if (evt_q) begin
         if (cmd == CMD_SPECIAL) begin
            if (!word_q.channel_select_lo) begin
               for (int i = 0; i < CHANNELS; i++) begin
                  in_d[i]  = word_q.sample_code;
                  dac_d[i] = word_q.sample_code;
               end
            end
            // A0 high is a no-operation word, left to pass along a chain.
         end else if (word_q.command_lo) begin
            in_d[chan] = word_q.sample_code;
            if (!ld_s2_q || cmd == CMD_LOAD_UP) begin
               dac_d[chan] = word_q.sample_code;
            end
            if (ld_s2_q && cmd == CMD_LOAD_UP) begin
               dac_d = in_d;
            end
         end else begin
            if (word_q.channel_select_hi) begin
               mode_d = word_q.channel_select_lo ? MODE_RISING : MODE_FALLING;
            end
            dac_d = in_q;
         end
      end else if (!ld_s2_q) begin
         dac_d = in_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         in_q   <= '0;
         dac_q  <= '0;
         mode_q <= MODE_RESET;
      end else begin
         in_q   <= in_d;
         dac_q  <= dac_d;
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         dac_code_o  <= '0;
         echo_mode_o <= MODE_RESET;
      end else begin
         dac_code_o  <= dac_d;
         echo_mode_o <= mode_d;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_cs_rise;
      cs_s2_q && !cs_s3_q;
   endsequence
   sequence s_evt;
      evt_q;
   endsequence
   sequence s_idle_latched;
      !evt_q && ld_s2_q;
   endsequence

   AST_ACT_ON_CS_RISE: assert property (s_cs_rise |=> s_evt)
      else $error("Command not taken one cycle after chip select rose.");
   AST_BROADCAST: assert property (evt_q && cmd == CMD_SPECIAL && !word_q.channel_select_lo
      |=> dac_q[0] == $past(word_q.sample_code) && dac_q[3] == $past(word_q.sample_code)
          && in_q[2] == $past(word_q.sample_code))
      else $error("Broadcast code not in every register.");
   AST_NOP: assert property (evt_q && cmd == CMD_SPECIAL && word_q.channel_select_lo && ld_s2_q
      |=> $stable(in_q) && $stable(dac_q))
      else $error("No-operation word changed a register.");
   AST_LOAD_ONLY: assert property (evt_q && cmd == CMD_LOAD && ld_s2_q
      |=> in_q[$past(chan)] == $past(word_q.sample_code) && $stable(dac_q))
      else $error("Input load touched the DAC registers or missed its input register.");
   AST_LOAD_UPDATE: assert property (evt_q && cmd == CMD_LOAD_UP && ld_s2_q
      |=> dac_q == in_q && dac_q[$past(chan)] == $past(word_q.sample_code))
      else $error("Load and update did not copy inputs to DACs.");
   AST_UPDATE_ALL: assert property (evt_q && cmd == CMD_UPDATE && !word_q.channel_select_hi
      |=> dac_q == $past(in_q))
      else $error("Update-all did not copy the input registers.");
   AST_MODE_RISING: assert property (evt_q && cmd == CMD_UPDATE && chan == 2'h3
      |=> mode_q == MODE_RISING && dac_q == $past(in_q) ##1 echo_mode_o == MODE_RISING)
      else $error("Rising echo mode not selected.");
   AST_MODE_FALLING: assert property (evt_q && cmd == CMD_UPDATE && chan == 2'h2
      |=> mode_q == MODE_FALLING && dac_q == $past(in_q))
      else $error("Falling echo mode not selected.");
   AST_TRANSPARENT_LOAD: assert property (evt_q && word_q.command_lo && !ld_s2_q
      |=> dac_q[$past(chan)] == $past(word_q.sample_code) ##1
          dac_code_o[$past(chan, 2)] == $past(word_q.sample_code, 2))
      else $error("Transparent load did not reach the DAC.");
   AST_LATCH_HOLD: assert property (!evt_q && ld_s2_q |=> $stable(dac_q))
      else $error("Latched DAC registers changed.");
   AST_TRANSPARENT: assert property (!ld_s2_q && !evt_q |=> dac_q == $past(in_q))
      else $error("Transparent DAC registers did not follow inputs.");

   // Nothing may change between commands except what the strobe allows.
   AST_EVT_SINGLE: assert property (s_evt |=> !evt_q)
      else $error("One chip-select rise produced two commands.");
   AST_INPUT_HOLD: assert property (!evt_q |=> $stable(in_q))
      else $error("An input register changed without a command.");
   AST_MODE_HOLD: assert property (!(evt_q && cmd == CMD_UPDATE && word_q.channel_select_hi)
      |=> $stable(mode_q))
      else $error("Echo mode changed without a mode word.");
   AST_OUT_HOLD: assert property (s_idle_latched |=> $stable(dac_code_o))
      else $error("Latched DAC outputs changed.");
endmodule

// ==== serial_host_model.sv ====
// Purpose: Host side of the serial command port: frames words and reads the echo.
// Assumes: Serial clock period 32 ns, running only while a frame is open.
// Notes:   Data changes while the clock is low, so the port sees it settled at each rise.
`timescale 1ns/1ps
module serial_host_model (
   // Serial link
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      sdi_o  = 1'b0;
   end

   // Sends one whole word and returns the echo seen just before and just after each rise.
   task automatic send(input logic [15:0] w, output logic [15:0] r, output logic [15:0] late);
      int i;
      cs_n_o = 1'b0;
      #20;
      for (i = 15; i >= 0; i--) begin
         sdi_o = w[i];
         #8 r[i] = sdo_i;
         #8 sck_o = 1'b1;
         #4 late[i] = sdo_i;
         #12 sck_o = 1'b0;
      end
      #16 cs_n_o = 1'b1;
      // The data line is driven to the inverse of the last bit, so it does not keep showing that bit.
      sdi_o = ~sdi_o;
      #200;
   endtask
endmodule

// ==== quad_dac_port_tb.sv ====
// Purpose: Self-checking bench for the serial command port.
// Assumes: Outputs settle within 5 reference cycles of chip select rising.
// Notes:   Eight cycles are waited after each frame to cover the crossing.
`timescale 1ns/1ps
module quad_dac_port_tb;
   import quad_dac_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic strobe_n = 1'b1;
   logic sck, cs_n, sdi, sdo, echo;
   logic [CHANNELS-1:0][CODE_BITS-1:0] dac;
   logic [15:0] rd;
   logic [15:0] late;
   int n_fail = 0;
   int n_tests = 0;

   quad_dac_port quad_dac_port_i (.ref_clk_i(ref_clk), .rstn_i(rstn), .sck_i(sck),
      .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .load_strobe_n_i(strobe_n),
      .dac_code_o(dac), .echo_mode_o(echo));
   serial_host_model serial_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi),
      .sdo_i(sdo));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cmd(input logic [3:0] hdr, input logic [11:0] code);
      serial_host_model_i.send({hdr, code}, rd, late);
      // Outputs are looked at mid-cycle, well away from the edge that launches them.
      repeat (8) @(negedge ref_clk);
   endtask

   initial begin
      #2000000;
      n_fail++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check(dac, 48'h0);
      check(echo, MODE_RISING);
      cmd(4'h1, 12'h123);
      check(dac, 48'h0);
      cmd(4'h7, 12'h456);
      check(dac, {12'h0, 12'h0, 12'h456, 12'h123});
      cmd(4'h9, 12'h789);
      check(dac, {12'h0, 12'h0, 12'h456, 12'h123});
      // A0 set in the update word must not matter.
      cmd(4'h6, 12'hfff);
      check(dac, {12'h0, 12'h789, 12'h456, 12'h123});
      cmd(4'hd, 12'habc);
      cmd(4'h4, 12'h5a5);
      check(dac, {12'h0, 12'h789, 12'h456, 12'h123});
      cmd(4'ha, 12'h000);
      check(dac, {12'habc, 12'h789, 12'h456, 12'h123});
      check(echo, MODE_FALLING);
      // In falling-edge echo a bit still stands just after the rise that shifts it.
      cmd(4'h4, 12'h0c3);
      cmd(4'h4, 12'h000);
      check(rd, 16'h40c3);
      check(late, 16'h40c3);
      cmd(4'he, 12'h000);
      check(echo, MODE_RISING);
      cmd(4'h8, 12'h5a5);
      check(dac, {4{12'h5a5}});
      cmd(4'h4, 12'h03c);
      cmd(4'h4, 12'h000);
      check(rd, 16'h403c);
      check(late, 16'h8078);
      cmd(4'h1, 12'h111);
      check(dac, {4{12'h5a5}});
      @(posedge ref_clk) strobe_n <= 1'b0;
      repeat (8) @(negedge ref_clk);
      check(dac, {12'h5a5, 12'h5a5, 12'h5a5, 12'h111});
      cmd(4'h9, 12'h222);
      check(dac, {12'h5a5, 12'h222, 12'h5a5, 12'h111});
      cmd(4'hf, 12'h333);
      check(dac, {12'h333, 12'h222, 12'h5a5, 12'h111});
      stop_test();
   end
endmodule
